/* File: drs_cfg.svh */
// Functional notes
// - Low pulses on the reset line shorter than 5 us are ignored.
// - A low pulse longer than 9 us always resets; between 5 and 9 us a reset may begin.
// - A short high glitch during a held reset neither ends nor restarts it.
// - Each release of the reset line after an accepted reset loads ID bytes, electrode level and settings from NVM.
// - Reset cancel ends within 5 ms from low-power state and within 120 ms when awake.
// - During reset the display is blanked, with a blanking run of at most 120 ms when awake.
// - When a reset is accepted all settings take their hardware reset defaults, before the NVM load.
`ifndef DRS_CFG_SVH
`define DRS_CFG_SVH
`define DRS_CLK_MHZ         100
`define DRS_REJECT_US       5
`define DRS_ACCEPT_US       9
`define DRS_GLITCH_US       5
`define DRS_CANCEL_SLP_MS   5
`define DRS_CANCEL_AWK_MS   120
`define DRS_BLANK_MS        120
`define DRS_ACCEPT_CYC      (`DRS_ACCEPT_US * `DRS_CLK_MHZ)
`define DRS_GLITCH_CYC      (`DRS_GLITCH_US * `DRS_CLK_MHZ)
`define DRS_CANCEL_SLP_CYC  (`DRS_CANCEL_SLP_MS * 1000 * `DRS_CLK_MHZ)
`define DRS_CANCEL_AWK_CYC  (`DRS_CANCEL_AWK_MS * 1000 * `DRS_CLK_MHZ)
`define DRS_BLANK_CYC       (`DRS_BLANK_MS * 1000 * `DRS_CLK_MHZ)
`define DRS_NVM_WORDS       8
`define DRS_SET_RST_DEFAULT 8'h00
`endif

/* File: drs_pkg.sv */
package drs_pkg;
    typedef enum logic [2:0] {
        DRS_IDLE,
        DRS_HOLD,
        DRS_BLANK,
        DRS_WAIT_REL,
        DRS_LOAD,
        DRS_CANCEL
    } drs_state_type;

    typedef struct packed {
        logic       blank;
        logic       cmd_ok;
        logic       wake_ok;
        logic       load_busy;
    } drs_stat_type;
endpackage

/* File: drs_nvm.sv */
`timescale 1ns/1ps
`default_nettype none
module drs_nvm #(
    parameter int DEPTH = 8,
    parameter int AW    = 3
) (
    input  wire logic          clk,
    input  wire logic          rstn,
    input  wire logic          ce,
    input  wire logic [AW-1:0] raddr,
    output logic      [7:0]    rdata,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [7:0]    wdata
);
    logic [7:0] mem [DEPTH];

    always_ff @(posedge clk)
    begin
        if (ce && we)
            mem[waddr] <= wdata;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            rdata <= 8'h00;
        else if (ce)
            rdata <= mem[raddr];
    end
endmodule
`default_nettype wire

/* File: drs_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "drs_cfg.svh"
module drs_top #(
    parameter int ACCEPT_CYC = `DRS_ACCEPT_CYC,
    parameter int GLITCH_CYC = `DRS_GLITCH_CYC,
    parameter int SLP_CYC    = `DRS_CANCEL_SLP_CYC,
    parameter int AWK_CYC    = `DRS_CANCEL_AWK_CYC,
    parameter int BLANK_CYC  = `DRS_BLANK_CYC,
    parameter int NVM_WORDS  = `DRS_NVM_WORDS
) (
    input  wire logic               CLK,
    input  wire logic               RSTN,
    input  wire logic               CE,
    input  wire logic               HW_RESET_LINE_N,
    input  wire logic               SLEEP_IN,
    input  wire logic               NVM_WE,
    input  wire logic [2:0]         NVM_WADDR,
    input  wire logic [7:0]         NVM_WDATA,
    output drs_pkg::drs_stat_type   STAT,
    output logic                    SET_WE,
    output logic [2:0]              SET_ADDR,
    output logic [7:0]              SET_DATA,
    output logic                    SETTINGS_DEFAULT
);
    import drs_pkg::*;

    localparam int CW = 24;

    drs_state_type state_r;
    logic [CW-1:0] low_cnt_r;
    logic [CW-1:0] hi_cnt_r;
    logic [CW-1:0] seq_cnt_r;
    logic [CW-1:0] rel_cnt_r;
    logic          slept_r;
    logic [2:0]    ld_idx_r;
    logic          ld_phase_r;
    logic [7:0]    nvm_rdata;
    logic          last_word;

    assign last_word = (ld_idx_r == 3'(NVM_WORDS - 1));

    drs_nvm #(.DEPTH(NVM_WORDS), .AW(3)) drs_nvm_inst (
        .clk   (CLK),
        .rstn  (RSTN),
        .ce    (CE),
        .raddr (ld_idx_r),
        .rdata (nvm_rdata),
        .we    (NVM_WE),
        .waddr (NVM_WADDR),
        .wdata (NVM_WDATA)
    );

    // Low time filter; any high clears count
    always_ff @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
            low_cnt_r <= '0;
        else if (CE)
        begin
            if (HW_RESET_LINE_N)
                low_cnt_r <= '0;
            else if (low_cnt_r != CW'(ACCEPT_CYC))
                low_cnt_r <= low_cnt_r + 1'b1;
        end
    end

    // High time while a reset is held
    always_ff @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
            hi_cnt_r <= '0;
        else if (CE)
        begin
            if (!HW_RESET_LINE_N)
                hi_cnt_r <= '0;
            else if (hi_cnt_r != CW'(GLITCH_CYC))
                hi_cnt_r <= hi_cnt_r + 1'b1;
        end
    end

    always_ff @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
            state_r <= DRS_IDLE;
        else if (CE)
        begin
            unique case (state_r)
                DRS_IDLE, DRS_LOAD, DRS_CANCEL:
                    if (low_cnt_r == CW'(ACCEPT_CYC))
                        state_r <= DRS_HOLD;
                    else if (state_r == DRS_LOAD && ld_phase_r && last_word)
                        state_r <= DRS_CANCEL;
                    else if (state_r == DRS_CANCEL && seq_cnt_r == '0)
                        state_r <= DRS_IDLE;
                DRS_HOLD:
                    state_r <= slept_r ? DRS_WAIT_REL : DRS_BLANK;
                DRS_BLANK:
                    if (seq_cnt_r == '0)
                        state_r <= DRS_WAIT_REL;
                    else if (hi_cnt_r == CW'(GLITCH_CYC))
                        state_r <= DRS_WAIT_REL;
                DRS_WAIT_REL:
                    if (hi_cnt_r == CW'(GLITCH_CYC))
                        state_r <= DRS_LOAD;
                default:
                    state_r <= DRS_IDLE;
            endcase
        end
    end

    // Mode latched when the reset was applied
    always_ff @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
            slept_r <= 1'b1;
        else if (CE && state_r != DRS_HOLD && state_r != DRS_BLANK
                 && state_r != DRS_WAIT_REL && low_cnt_r == CW'(ACCEPT_CYC))
            slept_r <= SLEEP_IN;
    end

    // Blanking and cancel timers
    always_ff @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
            seq_cnt_r <= '0;
        else if (CE)
        begin
            if (state_r == DRS_HOLD)
                seq_cnt_r <= CW'(BLANK_CYC - 1);
            else if (state_r == DRS_WAIT_REL && hi_cnt_r == CW'(GLITCH_CYC))
                seq_cnt_r <= slept_r ? CW'(SLP_CYC - GLITCH_CYC - NVM_WORDS * 2 - 2)
                                     : CW'(AWK_CYC - GLITCH_CYC - NVM_WORDS * 2 - 2);
            else if (seq_cnt_r != '0 && state_r != DRS_WAIT_REL)
                seq_cnt_r <= seq_cnt_r - 1'b1;
        end
    end

    // Time since release for host gating flags
    always_ff @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
            rel_cnt_r <= '0;
        else if (CE)
        begin
            if (state_r == DRS_HOLD || state_r == DRS_BLANK || state_r == DRS_WAIT_REL)
                rel_cnt_r <= CW'(GLITCH_CYC);
            else if (rel_cnt_r != CW'(AWK_CYC))
                rel_cnt_r <= rel_cnt_r + 1'b1;
        end
    end

    // NVM copy: read phase then write phase per word
    always_ff @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            ld_idx_r   <= 3'h0;
            ld_phase_r <= 1'b0;
            SET_WE     <= 1'b0;
            SET_ADDR   <= 3'h0;
            SET_DATA   <= 8'h00;
        end
        else if (CE)
        begin
            SET_WE <= 1'b0;
            if (state_r != DRS_LOAD)
            begin
                ld_idx_r   <= 3'h0;
                ld_phase_r <= 1'b0;
            end
            else if (!ld_phase_r)
                ld_phase_r <= 1'b1;
            else
            begin
                SET_WE     <= 1'b1;
                SET_ADDR   <= ld_idx_r;
                SET_DATA   <= nvm_rdata;
                ld_phase_r <= 1'b0;
                ld_idx_r   <= ld_idx_r + 3'h1;
            end
        end
    end

    always_ff @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            STAT             <= '{blank: 1'b1, cmd_ok: 1'b0, wake_ok: 1'b0, load_busy: 1'b0};
            SETTINGS_DEFAULT <= 1'b0;
        end
        else if (CE)
        begin
            STAT.blank       <= (state_r != DRS_IDLE);
            STAT.cmd_ok      <= (state_r == DRS_IDLE || state_r == DRS_CANCEL)
                                && rel_cnt_r >= CW'(SLP_CYC);
            STAT.wake_ok     <= (state_r == DRS_IDLE) && rel_cnt_r == CW'(AWK_CYC);
            STAT.load_busy   <= (state_r == DRS_LOAD);
            SETTINGS_DEFAULT <= (state_r == DRS_HOLD);
        end
    end

    a_short_reject: assert property (@(posedge CLK) disable iff (!RSTN)
        (state_r == DRS_IDLE && low_cnt_r != CW'(ACCEPT_CYC)) |=> state_r != DRS_HOLD)
        else $error("Reset accepted on short pulse");

    a_long_accept: assert property (@(posedge CLK) disable iff (!RSTN)
        (CE && low_cnt_r == CW'(ACCEPT_CYC) && state_r == DRS_IDLE) |=> state_r == DRS_HOLD)
        else $error("Long pulse not accepted");

    a_glitch_hold: assert property (@(posedge CLK) disable iff (!RSTN)
        (state_r == DRS_WAIT_REL && hi_cnt_r < CW'(GLITCH_CYC)) |=> state_r == DRS_WAIT_REL)
        else $error("Glitch ended reset");

    a_load_writes: assert property (@(posedge CLK) disable iff (!RSTN)
        (CE && state_r == DRS_LOAD && ld_phase_r) |=> SET_WE)
        else $error("NVM word not written");

    a_default_pulse: assert property (@(posedge CLK) disable iff (!RSTN)
        (CE && state_r == DRS_HOLD) |=> SETTINGS_DEFAULT)
        else $error("Defaults not applied");

    a_blank_during: assert property (@(posedge CLK) disable iff (!RSTN)
        (CE && state_r == DRS_WAIT_REL) |=> STAT.blank)
        else $error("Display not blanked");

    a_no_cmd_early: assert property (@(posedge CLK) disable iff (!RSTN)
        (state_r == DRS_LOAD) |=> !STAT.cmd_ok)
        else $error("Commands allowed during load");

    a_wake_gate: assert property (@(posedge CLK) disable iff (!RSTN)
        STAT.wake_ok |-> $past(rel_cnt_r) == CW'(AWK_CYC))
        else $error("Wake allowed early");
endmodule
`default_nettype wire

/* File: drs_host.sv */
`timescale 1ns/1ps
`default_nettype none
module drs_host #(
    parameter int SLP_CYC = 100,
    parameter int AWK_CYC = 300
) (
    input  wire logic clk,
    output logic      line_n,
    output logic      may_cmd,
    output logic      may_wake
);
    int rel_cnt = 0;

    initial line_n = 1'b1;

    // Time since the line was last released
    always @(posedge clk)
    begin
        rel_cnt <= line_n ? rel_cnt + 1 : 0;
    end

    assign may_cmd  = rel_cnt >= SLP_CYC;
    assign may_wake = rel_cnt >= AWK_CYC;

    // Low phase, optional high glitch, second low phase
    task automatic pulse(input int lo1, input int gl, input int lo2);
        begin
            @(posedge clk);
            #1 line_n = 1'b0;
            repeat (lo1) @(posedge clk);
            if (gl > 0)
            begin
                #1 line_n = 1'b1;
                repeat (gl) @(posedge clk);
                #1 line_n = 1'b0;
                repeat (lo2) @(posedge clk);
            end
            #1 line_n = 1'b1;
        end
    endtask
endmodule
`default_nettype wire

/* File: drs_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module drs_top_tb;
    import drs_pkg::*;
    localparam int GL = 5;
    localparam int SLP = 100;
    localparam int AWK = 300;
    logic          clk = 1'b0;
    logic          rstn = 1'b0;
    logic          ce = 1'b1;
    logic          sleep = 1'b0;
    logic          nvm_we = 1'b0;
    logic [2:0]    nvm_waddr = 3'h0;
    logic [7:0]    nvm_wdata = 8'h00;
    logic          line_n;
    logic          may_cmd;
    logic          may_wake;
    logic [11:0]   seen;
    int            b;
    int            c;
    drs_stat_type  stat;
    logic          set_we;
    logic [2:0]    set_addr;
    logic [7:0]    set_data;
    logic          dflt;
    logic [7:0]    mem [8];
    logic [11:0]   exp_q [$];
    int            seed = 32'h1143e868;
    int            errors = 0;
    int            checked = 0;
    int            n;
    int            lo1_t [4] = '{8, 12, 9, 60};
    int            gl_t [4] = '{0, 3, 0, 0};
    logic          slp_t [4] = '{1'b0, 1'b0, 1'b1, 1'b0};
    logic          hit_t [4] = '{1'b0, 1'b1, 1'b1, 1'b1};
    int            bnd_t [4] = '{10, AWK, SLP, AWK};

    always #5 clk = ~clk;

    drs_top #(.ACCEPT_CYC(9), .GLITCH_CYC(GL), .SLP_CYC(SLP), .AWK_CYC(AWK),
              .BLANK_CYC(50), .NVM_WORDS(8)) drs_top_inst (
        .CLK(clk), .RSTN(rstn), .CE(ce), .HW_RESET_LINE_N(line_n), .SLEEP_IN(sleep),
        .NVM_WE(nvm_we), .NVM_WADDR(nvm_waddr), .NVM_WDATA(nvm_wdata), .STAT(stat),
        .SET_WE(set_we), .SET_ADDR(set_addr), .SET_DATA(set_data),
        .SETTINGS_DEFAULT(dflt));

    drs_host #(.SLP_CYC(SLP), .AWK_CYC(AWK)) drs_host_inst (
        .clk(clk), .line_n(line_n), .may_cmd(may_cmd), .may_wake(may_wake));

    task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
        begin
            checked++;
            if (seen !== exp)
            begin
                errors++;
                $display("[FAIL] %s expected %h seen %h", what, exp, seen);
            end
        end
    endtask

    task automatic end_of_test();
        begin
            $display("checked %0d errors %0d", checked, errors);
            if (errors == 0 && checked > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask

    // Every copy or default pulse takes the oldest note
    always @(negedge clk)
    begin
        if (set_we === 1'b1 || dflt === 1'b1)
        begin
            // Address and data lines carry stale values during the default pulse
            seen = {dflt, dflt ? 11'h000 : {set_addr, set_data}};
            if (set_we === 1'b1)
                check("load_busy", {11'h0, stat.load_busy}, 12'h1);
            if (exp_q.size() == 0)
                check("unexpected_write", seen, 12'hfff);
            else
                check("write", seen, exp_q.pop_front());
        end
    end

    initial
    begin
        repeat (8) @(posedge clk);
        #1 rstn = 1'b1;
        for (int i = 0; i < 8; i++)
        begin
            @(posedge clk);
            mem[i] = 8'($random(seed));
            #1 nvm_we = 1'b1;
            nvm_waddr = i[2:0];
            nvm_wdata = mem[i];
        end
        @(posedge clk);
        #1 nvm_we = 1'b0;
        for (int t = 0; t < 4; t++)
        begin
            n = 0;
            while (may_cmd !== 1'b1 && n < 1000)
            begin
                @(posedge clk);
                n++;
            end
            if (n >= 1000)
            begin
                errors++;
                $display("[FAIL] may_cmd expected 1 seen %b", may_cmd);
                end_of_test();
            end
            #1 sleep = slp_t[t];
            if (hit_t[t])
            begin
                exp_q.push_back(12'h800);
                for (int i = 0; i < 8; i++)
                    exp_q.push_back({1'b0, i[2:0], mem[i]});
            end
            drs_host_inst.pulse(lo1_t[t], gl_t[t], 10);
            // Acceptance shows two cycles after the last low sample
            repeat (2) @(posedge clk);
            #1 check("blank_held", {11'h0, stat.blank}, {11'h0, hit_t[t]});
            // Cycles since release until blank drops and until commands open
            n = 2;
            b = 0;
            c = 0;
            while ((b == 0 || c == 0) && n < 2 * AWK)
            begin
                @(posedge clk);
                #1 n++;
                if (b == 0 && stat.blank === 1'b0)
                    b = n;
                if (c == 0 && stat.cmd_ok === 1'b1)
                    c = n;
            end
            if (n >= 2 * AWK)
            begin
                errors++;
                $display("[FAIL] cancel_time expected below %0d seen %0d", bnd_t[t], n);
                end_of_test();
            end
            check("cancel_time", {11'h0, (b <= bnd_t[t])}, 12'h1);
            if (hit_t[t])
                check("cmd_wait", {11'h0, (c >= SLP)}, 12'h1);
            repeat (3) @(posedge clk);
            #1 check("notes_left", 12'(exp_q.size()), 12'h0);
            if (hit_t[t])
                check("cmd_ok", {11'h0, stat.cmd_ok}, 12'h1);
            $display("test %0d done", t);
        end
        // Wake permission must not come before the host's own wait
        n = 0;
        while (stat.wake_ok !== 1'b1 && n < 2 * AWK)
        begin
            @(posedge clk);
            #1 n++;
        end
        check("wake_ok", {11'h0, stat.wake_ok}, 12'h1);
        check("wake_gate", {11'h0, may_wake}, 12'h1);
        $display("test 4 done");
        // Long low pulse while the clock enable is low must be ignored
        #1 ce = 1'b0;
        drs_host_inst.pulse(20, 0, 0);
        repeat (2) @(posedge clk);
        #1 check("ce_frozen", {11'h0, stat.blank}, 12'h0);
        ce = 1'b1;
        repeat (20) @(posedge clk);
        #1 check("ce_resumed", {11'h0, stat.blank}, 12'h0);
        check("ce_notes_left", 12'(exp_q.size()), 12'h0);
        $display("test 5 done");
        end_of_test();
    end
endmodule
`default_nettype wire
